// *** design/calendar_clock_pkg.sv ***
// package: register map, field positions, reset values and counts for
// the calendar-clock alarm, divider and power-window block.
// assumes a 32-bit word-per-register slave; registers sit in low 16 bits.
package calendar_clock_pkg;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_CONTROL = 10'h1_cc;
   localparam logic [9:0] IDX_ALARM_CONTROL = 10'h1_ce;
   localparam logic [9:0] IDX_CLOCK_SOURCE_PRESCALE = 10'h1_d0;
   localparam logic [9:0] IDX_DIVIDER_PERIOD = 10'h1_d2;
   localparam logic [9:0] IDX_POWER_WINDOW_TIMERS = 10'h1_d4;
   localparam logic [9:0] IDX_STATUS = 10'h1_d8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTL_WRITE_LOCK = 11;
   localparam int CTL_POWER_CTL_ON = 10;
   localparam int ALC_ALARM_ON = 15;
   localparam int ALC_CHIME = 14;
   localparam int ALC_MASK_LSB = 8;
   localparam int ALC_REPEAT_LSB = 0;
   localparam int CSP_TRIM_LSB = 11;
   localparam int CSP_PWC_PS_LSB = 6;
   localparam int CSP_COUNT_PS_LSB = 4;
   localparam int CSP_SOURCE_LSB = 0;
   localparam int PWT_SAMPLE_LSB = 8;
   localparam int PWT_STAB_LSB = 0;
   localparam int STS_ALARM_EVENT = 5;
   localparam int STS_HALF_PHASE = 0;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [15:0] RESET_REG16 = 16'h0000;
   localparam logic [7:0] RESET_REG8 = 8'h00;
   localparam logic [7:0] REPEAT_MAX = 8'hff;
   localparam logic [7:0] SAMPLE_ALWAYS = 8'hff;
   localparam int TRIM_PERIOD_SECONDS = 16;
   localparam int HALF_TICKS_PER_SECOND = 2;
   localparam logic [4:0] TRIM_PERIOD_LAST =
      5'(TRIM_PERIOD_SECONDS * HALF_TICKS_PER_SECOND - 1);
   localparam logic [7:0] PS_LAST_1 = 8'h00;
   localparam logic [7:0] PS_LAST_16 = 8'h0f;
   localparam logic [7:0] PS_LAST_64 = 8'h3f;
   localparam logic [7:0] PS_LAST_256 = 8'hff;

   // ----------------------------------------------------------------
   // helpers for the register, prescaler and alarm logic
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old_value,
         input logic [31:0] wdata, input logic [3:0] be);
      merge16 = {be[1] ? wdata[15:8] : old_value[15:8],
                 be[0] ? wdata[7:0] : old_value[7:0]};
   endfunction : merge16

   function automatic logic [7:0] ps_last(input logic [1:0] code);
      case (code)
         2'b00: ps_last = PS_LAST_1;
         2'b01: ps_last = PS_LAST_16;
         2'b10: ps_last = PS_LAST_64;
         default: ps_last = PS_LAST_256;
      endcase
   endfunction : ps_last

   // fields that must match: bit0 sec ones .. 5 weekday, 6 day, 7 month
   function automatic logic [8:0] mask_need(input logic [3:0] code);
      case (code)
         4'b0000: mask_need = 9'h0_00;
         4'b0001: mask_need = 9'h1_00;
         4'b0010: mask_need = 9'h1_01;
         4'b0011: mask_need = 9'h1_03;
         4'b0100: mask_need = 9'h1_07;
         4'b0101: mask_need = 9'h1_0f;
         4'b0110: mask_need = 9'h1_1f;
         4'b0111: mask_need = 9'h1_3f;
         4'b1000: mask_need = 9'h1_5f;
         4'b1001: mask_need = 9'h1_df;
         default: mask_need = 9'h0_00;
      endcase
   endfunction : mask_need

   typedef enum logic [1:0] {
      SRC_SECONDARY_OSCILLATOR,
      SRC_LOW_POWER_RC_OSC,
      SRC_MAINS_CLOCK_PIN,
      SRC_PERIPHERAL
   } source_select_t;

   typedef enum {
      PW_IDLE,
      PW_STABILITY,
      PW_SAMPLE
   } power_window_state_t;

endpackage : calendar_clock_pkg

// *** design/calendar_clock_alarm_divider.sv ***
// file: alarm repeat logic, time-base source select, prescalers,
// fractional trim, half-second divider and power-control windows.
// assumes source ticks and calendar match inputs are synchronous to
// clk_in; the calendar counters themselves live in a neighbouring block.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module calendar_clock_alarm_divider (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // avalon-mm slave
   input wire logic [11:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // time-base source ticks, one bit per source
   input wire logic [3:0] source_tick_in,
   // calendar field matches from the neighbouring calendar block
   input wire logic [7:0] field_match_in,
   // events and windows
   output logic half_sec_tick_out,
   output logic alarm_event_out,
   output logic stability_window_out,
   output logic sample_window_out
);
   import calendar_clock_pkg::*;

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic write_lock;
   logic power_ctl_on;
   logic alarm_on;
   logic chime;
   logic [3:0] alarm_period_mask;
   logic [7:0] alarm_repeat_count;
   logic [4:0] fractional_trim;
   logic [1:0] power_ctl_prescale;
   logic [1:0] count_prescale;
   logic [1:0] source_select;
   logic [15:0] divisor;
   logic [7:0] sample_window_length;
   logic [7:0] stability_window_length;
   logic alarm_event_flag;
   logic half_phase;
   logic bus_ack;
   logic [7:0] count_ps_cnt;
   logic [7:0] pwc_ps_cnt;
   logic [15:0] div_cnt;
   logic [4:0] half_tick_cnt;
   logic [4:0] trim_left;
   logic alarm_check;
   logic [7:0] window_cnt;
   power_window_state_t pw_state;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire logic [9:0] reg_index = avs_address_in[11:2];
   wire logic bus_req = avs_read_in | avs_write_in;
   wire logic wr_go = avs_write_in & bus_ack;
   wire logic rd_first = avs_read_in & ~bus_ack;
   wire logic sel_control = reg_index == IDX_CONTROL;
   wire logic sel_alarm = reg_index == IDX_ALARM_CONTROL;
   wire logic sel_source = reg_index == IDX_CLOCK_SOURCE_PRESCALE;
   wire logic sel_divider = reg_index == IDX_DIVIDER_PERIOD;
   wire logic sel_power = reg_index == IDX_POWER_WINDOW_TIMERS;
   wire logic sel_status = reg_index == IDX_STATUS;
   // alarm, source and power registers take no writes while the lock bit is set; the divider takes writes only while it is set
   wire logic wr_unlocked = wr_go & ~write_lock;
   wire logic wr_control = wr_go & sel_control;
   wire logic wr_alarm = wr_unlocked & sel_alarm;
   wire logic wr_source = wr_unlocked & sel_source;
   wire logic wr_divider = wr_go & sel_divider & write_lock;
   wire logic wr_power = wr_unlocked & sel_power;
   wire logic wr_status = wr_go & sel_status;

   wire logic [15:0] control_view =
      16'({write_lock, power_ctl_on}) << CTL_POWER_CTL_ON;
   wire logic [15:0] alarm_view = {alarm_on, chime, 2'b00,
      alarm_period_mask, alarm_repeat_count};
   wire logic [15:0] source_view = {fractional_trim, 3'b000,
      power_ctl_prescale, count_prescale, 2'b00, source_select};
   wire logic [15:0] power_view = {sample_window_length,
      stability_window_length};
   wire logic [15:0] status_view =
      (16'(alarm_event_flag) << STS_ALARM_EVENT) |
      (16'(half_phase) << STS_HALF_PHASE);
   wire logic [15:0] read_mux =
      sel_control ? control_view :
      sel_alarm ? alarm_view :
      sel_source ? source_view :
      sel_divider ? divisor :
      sel_power ? power_view :
      sel_status ? status_view : RESET_REG16;

   wire logic [15:0] new_control =
      merge16(control_view, avs_writedata_in, avs_byteenable_in);
   wire logic [15:0] new_alarm =
      merge16(alarm_view, avs_writedata_in, avs_byteenable_in);
   wire logic [15:0] new_source =
      merge16(source_view, avs_writedata_in, avs_byteenable_in);
   wire logic [15:0] new_power =
      merge16(power_view, avs_writedata_in, avs_byteenable_in);
   wire logic [15:0] new_status =
      merge16(status_view, avs_writedata_in, avs_byteenable_in);

   // every access waits exactly one cycle
   assign avs_waitrequest_out = bus_req & ~bus_ack;

   // ----------------------------------------------------------------
   // time base: source, trim, prescaler, divider
   // ----------------------------------------------------------------
   wire logic src_tick = source_tick_in[source_select];
   // trim swallows input ticks ahead of the prescaler
   wire logic trim_swallow = src_tick & (trim_left != 5'd0);
   wire logic count_in = src_tick & ~trim_swallow;
   wire logic count_ps_wrap =
      count_in & (count_ps_cnt >= ps_last(count_prescale));
   wire logic pwc_tick =
      src_tick & (pwc_ps_cnt >= ps_last(power_ctl_prescale));
   wire logic div_underflow = count_ps_wrap & (div_cnt == 16'h0000);
   wire logic trim_reload = div_underflow &
      (half_tick_cnt == TRIM_PERIOD_LAST);

   // ----------------------------------------------------------------
   // alarm decision
   // ----------------------------------------------------------------
   wire logic [8:0] need = mask_need(alarm_period_mask);
   // reserved codes never match, so they fire nothing
   wire logic mask_valid = alarm_period_mask <= 4'b1001;
   wire logic [8:0] have = {~half_phase, field_match_in};
   // leap day alarm repeats only when the calendar reaches Feb 29
   wire logic fire = alarm_check & alarm_on & mask_valid &
      ((need & have) == need);
   wire logic repeat_zero = alarm_repeat_count == 8'h00;

   wire logic window_last = pwc_tick & (window_cnt <= 8'd1);

   // ----------------------------------------------------------------
   // bus and configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_ack <= 1'b0;
         avs_readdata_out <= 32'h0000_0000;
      end else begin
         bus_ack <= bus_req & ~bus_ack;
         if (rd_first) begin
            avs_readdata_out <= {16'h0000, read_mux};
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         write_lock <= 1'b0;
         power_ctl_on <= 1'b0;
      end else if (wr_control) begin
         write_lock <= new_control[CTL_WRITE_LOCK];
         power_ctl_on <= new_control[CTL_POWER_CTL_ON];
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fractional_trim <= 5'd0;
         power_ctl_prescale <= 2'd0;
         count_prescale <= 2'd0;
         source_select <= 2'd0;
         divisor <= RESET_REG16;
         sample_window_length <= RESET_REG8;
         stability_window_length <= RESET_REG8;
      end else begin
         if (wr_source) begin
            fractional_trim <= new_source[CSP_TRIM_LSB +: 5];
            power_ctl_prescale <= new_source[CSP_PWC_PS_LSB +: 2];
            count_prescale <= new_source[CSP_COUNT_PS_LSB +: 2];
            source_select <= new_source[CSP_SOURCE_LSB +: 2];
         end
         if (wr_divider) begin
            divisor <= merge16(divisor, avs_writedata_in,
               avs_byteenable_in);
         end
         if (wr_power) begin
            sample_window_length <= new_power[PWT_SAMPLE_LSB +: 8];
            stability_window_length <= new_power[PWT_STAB_LSB +: 8];
         end
      end
   end

   // alarm control: hardware update wins over a same-cycle write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         alarm_on <= 1'b0;
         chime <= 1'b0;
         alarm_period_mask <= 4'd0;
         alarm_repeat_count <= RESET_REG8;
      end else begin
         if (wr_alarm) begin
            alarm_on <= new_alarm[ALC_ALARM_ON];
            chime <= new_alarm[ALC_CHIME];
            alarm_period_mask <= new_alarm[ALC_MASK_LSB +: 4];
            alarm_repeat_count <= new_alarm[ALC_REPEAT_LSB +: 8];
         end
         if (fire) begin
            if (!repeat_zero) begin
               alarm_repeat_count <= alarm_repeat_count - 8'd1;
            end else if (chime) begin
               alarm_repeat_count <= REPEAT_MAX;
            end else begin
               alarm_repeat_count <= 8'h00;
               alarm_on <= 1'b0;
            end
         end
      end
   end

   // alarm flag: software writes zero to clear; a new event wins
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         alarm_event_flag <= 1'b0;
         alarm_event_out <= 1'b0;
      end else begin
         alarm_event_out <= fire;
         if (fire) begin
            alarm_event_flag <= 1'b1;
         end else if (wr_status) begin
            alarm_event_flag <= alarm_event_flag &
               new_status[STS_ALARM_EVENT];
         end
      end
   end

   // ----------------------------------------------------------------
   // time-base counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_ps_cnt <= 8'h00;
         pwc_ps_cnt <= 8'h00;
         div_cnt <= 16'h0000;
         half_tick_cnt <= 5'd0;
         trim_left <= 5'd0;
         half_phase <= 1'b0;
         half_sec_tick_out <= 1'b0;
         alarm_check <= 1'b0;
      end else begin
         if (count_in) begin
            count_ps_cnt <= count_ps_wrap ? 8'h00 : count_ps_cnt + 8'd1;
         end
         if (src_tick) begin
            pwc_ps_cnt <= pwc_tick ? 8'h00 : pwc_ps_cnt + 8'd1;
         end
         if (count_ps_wrap) begin
            div_cnt <= div_underflow ? divisor : div_cnt - 16'd1;
         end
         if (div_underflow) begin
            half_tick_cnt <= half_tick_cnt + 5'd1;
            half_phase <= ~half_phase;
         end
         if (trim_reload) begin
            trim_left <= fractional_trim;
         end else if (trim_swallow) begin
            trim_left <= trim_left - 5'd1;
         end
         half_sec_tick_out <= div_underflow;
         // calendar steps on the tick; matches are read one cycle later
         alarm_check <= half_sec_tick_out;
      end
   end

   // ----------------------------------------------------------------
   // power-control stability and sample windows
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pw_state <= PW_IDLE;
         window_cnt <= 8'h00;
      end else begin
         case (pw_state)
            PW_IDLE: begin
               if (fire && power_ctl_on) begin
                  if (stability_window_length != 8'h00) begin
                     pw_state <= PW_STABILITY;
                     window_cnt <= stability_window_length;
                  end else if (sample_window_length != 8'h00) begin
                     pw_state <= PW_SAMPLE;
                     window_cnt <= sample_window_length;
                  end
               end
            end
            PW_STABILITY: begin
               if (!power_ctl_on) begin
                  pw_state <= PW_IDLE;
               end else if (window_last) begin
                  pw_state <= (sample_window_length != 8'h00) ?
                     PW_SAMPLE : PW_IDLE;
                  window_cnt <= sample_window_length;
               end else if (pwc_tick) begin
                  window_cnt <= window_cnt - 8'd1;
               end
            end
            PW_SAMPLE: begin
               if (!power_ctl_on || window_last) begin
                  pw_state <= PW_IDLE;
               end else if (pwc_tick) begin
                  window_cnt <= window_cnt - 8'd1;
               end
            end
            default: begin
               pw_state <= PW_IDLE;
            end
         endcase
      end
   end

   assign stability_window_out = pw_state == PW_STABILITY;
   // all-ones keeps sampling on regardless of the enable
   assign sample_window_out = (sample_window_length == SAMPLE_ALWAYS) |
      ((pw_state == PW_SAMPLE) & (sample_window_length != 8'h00));

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   a_alarm_auto_off: assert property (
      fire && repeat_zero && !chime && !wr_alarm |=> !alarm_on)
      else $error("alarm stayed enabled after last repeat");
   a_chime_wrap: assert property (
      fire && repeat_zero && chime && !wr_alarm |=>
         alarm_repeat_count == 8'hff && alarm_on)
      else $error("repeat count did not wrap under chime");
   a_repeat_hold: assert property (
      fire && repeat_zero && !chime && !wr_alarm |=>
         alarm_repeat_count == 8'h00)
      else $error("repeat count left zero without chime");
   a_repeat_dec: assert property (
      fire && !repeat_zero && !wr_alarm |=>
         alarm_repeat_count == $past(alarm_repeat_count) - 8'd1)
      else $error("repeat count did not decrement");
   a_flag_set: assert property (
      fire |=> alarm_event_flag && alarm_event_out)
      else $error("alarm event flag not set");
   a_alarm_needs_on: assert property (
      alarm_event_out |-> $past(alarm_on) && $past(alarm_check))
      else $error("alarm fired while disabled");
   a_divisor_locked: assert property (
      wr_go && sel_divider && !write_lock |=> $stable(divisor))
      else $error("divisor written while lock clear");
   a_sample_always: assert property (
      sample_window_length == 8'hff |-> sample_window_out)
      else $error("all-ones sample window not open");
   a_stab_zero: assert property (
      pw_state == PW_IDLE && fire && power_ctl_on && !wr_power &&
      stability_window_length == 8'h00 &&
      sample_window_length != 8'h00 |=> sample_window_out)
      else $error("sample window did not start at alarm");
   a_reload_tick: assert property (
      div_underflow |=> half_sec_tick_out && div_cnt == $past(divisor))
      else $error("divider did not reload on underflow");

endmodule : calendar_clock_alarm_divider
`default_nettype wire

// *** tb/tb_calendar_clock_alarm_divider.sv ***
// bench: model-checked registers, time base, alarm repeat and windows
// assumes calendar_clock_pkg and one 25 MHz clock; the bench plays the calendar
`timescale 1ns/1ps
`default_nettype none
module tb_calendar_clock_alarm_divider;
   import calendar_clock_pkg::*;
   logic clk_in = 0, resetn_in = 0, avs_read_in = 0, avs_write_in = 0;
   logic [11:0] avs_address_in = '0;
   logic [31:0] avs_writedata_in = '0, avs_readdata_out, q;
   logic [3:0] avs_byteenable_in = 4'h3, source_tick_in = '0;
   logic [7:0] field_match_in = '0, fm;
   logic avs_waitrequest_out, half_sec_tick_out, alarm_event_out;
   logic stability_window_out, sample_window_out;
   int n_errors = 0, samples_checked = 0, cyc = 0, tk = 0, tot = 0;
   int per = -1, skip = 2, halves = 0, events = 0, stab = 0, samp = 0;
   int sel = 0, h, e0;
   bit run = 0, all = 0;
   logic [15:0] mdl [logic [9:0]], wm [logic [9:0]], a;
   logic [7:0] req [10] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h07, 8'h0f,
      8'h1f, 8'h3f, 8'h5f, 8'hdf};
   int pt [4][4] = '{'{16'h0400, 16'h0302, 2, 3}, '{16'h0400, 16'h0400, 0, 4},
      '{16'h0400, 16'h0000, 0, 0}, '{16'h0000, 16'h0302, 0, 0}};

   calendar_clock_alarm_divider i_calendar_clock_alarm_divider (
      .clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out),
      .source_tick_in(source_tick_in), .field_match_in(field_match_in),
      .half_sec_tick_out(half_sec_tick_out), .alarm_event_out(alarm_event_out),
      .stability_window_out(stability_window_out),
      .sample_window_out(sample_window_out));

   always #20 clk_in = ~clk_in;

   // ----------------------------------------------------------------
   // ticks, hang guard and model
   // ----------------------------------------------------------------
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      source_tick_in <= !run ? 4'h0 : all ? 4'hf : 4'($urandom);
      if (cyc == 40000) begin
         n_errors++;
         results();
      end
   end

   // pre-edge values: an interval ends on the pulse, its tick opens the next
   always @(posedge clk_in) if (resetn_in) begin
      if (half_sec_tick_out === 1'b1) begin
         halves++;
         tot += tk;
         if (skip > 0) skip--;
         else if (per > 0) chk_cnt(tk, per);
         tk = 0;
      end
      tk += int'(source_tick_in[sel]);
      stab += int'(stability_window_out === 1'b1);
      samp += int'(sample_window_out === 1'b1);
      if (alarm_event_out === 1'b1) begin
         events++;
         a = mdl[IDX_ALARM_CONTROL];
         if (a[7:0] == 8'h00 && !a[ALC_CHIME]) a[ALC_ALARM_ON] = 1'b0;
         else a[7:0] = a[7:0] - 8'h01;
         mdl[IDX_ALARM_CONTROL] = a;
         mdl[IDX_STATUS][STS_ALARM_EVENT] = 1'b1;
      end
   end

   task automatic bus(input bit w, input logic [9:0] i, input logic [15:0] d);
      avs_address_in <= {i, 2'b00};
      avs_writedata_in <= {16'h0000, d};
      avs_write_in <= w;
      avs_read_in <= !w;
      @(posedge clk_in iff avs_waitrequest_out === 1'b0);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
   endtask : bus

   task automatic wr(input logic [9:0] i, input logic [15:0] d);
      bit lk;
      lk = mdl[IDX_CONTROL][CTL_WRITE_LOCK];
      bus(1'b1, i, d);
      if (i == IDX_STATUS) mdl[i][5] = mdl[i][5] & d[5];
      else if (mdl.exists(i) &&
         (i == IDX_DIVIDER_PERIOD ? lk : !lk || i == IDX_CONTROL))
         mdl[i] = d & wm[i];
   endtask : wr

   task automatic rd(input logic [9:0] i);
      logic [31:0] e;
      e = mdl.exists(i) ? {16'h0000, mdl[i]} : 32'h0000_0000;
      bus(1'b0, i, 16'h0000);
      if (i == IDX_STATUS) q[STS_HALF_PHASE] = 1'b0;
      chk_reg(q, e);
   endtask : rd

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_reg

   task automatic chk_cnt(input int g, input int e);
      samples_checked++;
      if (g != e) begin
         n_errors++;
         $display("Error at %0t: count %h expected %h", $time, g, e);
      end
   endtask : chk_cnt

   task automatic span(input int n);
      h = halves;
      wait (halves >= h + n);
   endtask : span

   // ticks stop first so no alarm can race a register write
   task automatic stop();
      run = 0;
      repeat (6) @(posedge clk_in);
   endtask : stop

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h8e3b_085d));
      wm[IDX_CONTROL] = 16'h0c00;
      wm[IDX_ALARM_CONTROL] = 16'hcfff;
      wm[IDX_CLOCK_SOURCE_PRESCALE] = 16'hf8f3;
      wm[IDX_DIVIDER_PERIOD] = 16'hffff;
      wm[IDX_POWER_WINDOW_TIMERS] = 16'hffff;
      wm[IDX_STATUS] = 16'h0000;
      foreach (wm[i]) mdl[i] = RESET_REG16;
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      foreach (wm[i]) rd(i);
      rd(10'h100);
      wr(IDX_DIVIDER_PERIOD, 16'h0005);
      wr(IDX_CONTROL, 16'h0800);
      wr(IDX_DIVIDER_PERIOD, 16'h0001);
      wr(IDX_ALARM_CONTROL, 16'h8123);
      foreach (wm[i]) rd(i);
      wr(IDX_CONTROL, 16'h0000);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(IDX_CLOCK_SOURCE_PRESCALE, 16'(c * 17));
         sel = c;
         per = c > 0 ? 8 << 2 * c : 2;
         skip = 2;
         run = 1;
         span(5);
         stop();
      end
      $display("test time base done");
      per = -1;
      sel = 0;
      wr(IDX_CLOCK_SOURCE_PRESCALE, 16'h1800);
      run = 1;
      span(2);
      tot = 0;
      span(32);
      chk_cnt(tot, 2 * 32 + 3);
      stop();
      $display("test trim done");
      wr(IDX_CLOCK_SOURCE_PRESCALE, 16'h0010);
      per = 32;
      skip = 2;
      wr(IDX_ALARM_CONTROL, 16'h8002);
      e0 = events;
      run = 1;
      span(8);
      stop();
      chk_cnt(events - e0, 3);
      rd(IDX_ALARM_CONTROL);
      wr(IDX_ALARM_CONTROL, 16'hc001);
      run = 1;
      span(6);
      stop();
      rd(IDX_ALARM_CONTROL);
      for (int m = 0; m < 10; m++) begin
         fm = $urandom % 2 ? 8'hff : 8'($urandom);
         field_match_in <= fm;
         wr(IDX_ALARM_CONTROL, {4'hc, 4'(m), 8'h00});
         run = 1;
         span(1);
         e0 = events;
         span(8);
         chk_cnt(events - e0, m == 0 ? 8 :
            (fm & req[m]) == req[m] ? 4 : 0);
         stop();
         rd(IDX_ALARM_CONTROL);
      end
      rd(IDX_STATUS);
      wr(IDX_STATUS, 16'h0000);
      rd(IDX_STATUS);
      $display("test alarm done");
      all = 1;
      for (int k = 0; k < 4; k++) begin
         wr(IDX_CONTROL, 16'(pt[k][0]));
         wr(IDX_POWER_WINDOW_TIMERS, 16'(pt[k][1]));
         wr(IDX_ALARM_CONTROL, 16'h8000);
         stab = 0;
         samp = 0;
         run = 1;
         span(3);
         stop();
         chk_cnt(stab, pt[k][2]);
         chk_cnt(samp, pt[k][3]);
      end
      wr(IDX_POWER_WINDOW_TIMERS, 16'hff00);
      chk_reg({31'h0, sample_window_out}, 32'h0000_0001);
      $display("test windows done");
      results();
   end
endmodule : tb_calendar_clock_alarm_divider
`default_nettype wire
